// >>> core/wid_adder.sv
// 16-bit increment with flag results
`timescale 1ns/1ps
`include "wid_regs.svh"
module wid_adder
(
    input  wire logic [7:0]  i_hi,
    input  wire logic [7:0]  i_lo,
    output logic      [15:0] o_sum,
    output logic             o_zero,
    output logic             o_sign,
    output logic             o_ovf
);
    // =========================================
    // increment
    wire logic [15:0] word_in;
    assign word_in = {i_hi, i_lo};                      // [RULE_06]
    assign o_sum   = word_in + `WID_WORD_ONE;           // [RULE_01]
    assign o_zero  = (o_sum == 16'h0000);               // [RULE_02]
    assign o_sign  = o_sum[15];                         // [RULE_03]
    assign o_ovf   = (word_in == `WID_WORD_MAXPOS);     // [RULE_04]
endmodule : wid_adder

// >>> core/wid_datapath.sv
// word increment execution datapath
// What this block does
// [RULE_01] even byte and next byte form one 16-bit word that gains one.
// [RULE_02] zero flag covers all 16 bits; carry, decimal, half-carry kept.
// [RULE_03] sign flag takes bit 15 of the result.
// [RULE_04] overflow flag is set only when 7fff increments to 8000.
// [RULE_05] indirect form reads the pair address from the named register.
// [RULE_06] high byte at even address, low byte next; carry runs low to high.
// [RULE_07] software tests a zero result by or-ing both result bytes.
// [RULE_08] a0 is the pair form, a1 the indirect; each takes eight cycles.
`timescale 1ns/1ps
`include "wid_regs.svh"
module wid_datapath
    import wid_pkg::*;
(
    input  wire logic       i_mclk,
    input  wire logic       i_rst,
    input  wire logic       i_start,
    input  wire logic [7:0] i_opcode,
    input  wire logic [7:0] i_dst,
    input  wire logic [7:0] i_flags,
    input  wire logic [7:0] i_rf_rdata,
    output logic      [7:0] o_rf_addr,
    output logic      [7:0] o_rf_wdata,
    output logic            o_rf_we,
    output logic      [7:0] o_flags,
    output logic            o_flags_we,
    output logic            o_busy,
    output logic            o_done,
    output logic            o_illegal
);
    // =========================================
    // decode
    wid_state_t  state_q, state_d;
    logic [7:0]  addr_q, hi_q, lo_q;
    logic [3:0]  cnt_q;
    logic [15:0] sum;
    logic        zero, sign, ovf;
    wire  logic  is_pair, is_ind, accept;
    wire  logic [7:0] even_ptr;
    assign is_pair  = (i_opcode == `WID_OPC_PAIR);      // [RULE_08]
    assign is_ind   = (i_opcode == `WID_OPC_IND);       // [RULE_08]
    assign accept   = i_start && (state_q == WID_IDLE);
    assign even_ptr = {i_rf_rdata[7:1], 1'b0};

    wid_adder u_adder
    (
        .i_hi   (hi_q),
        .i_lo   (lo_q),
        .o_sum  (sum),
        .o_zero (zero),
        .o_sign (sign),
        .o_ovf  (ovf)
    );

    // =========================================
    // sequence
    always_comb
    begin
        state_d = state_q;
        case (state_q)
            WID_IDLE:
            begin
                if (accept && is_ind)
                    state_d = WID_PTR_RD;               // [RULE_05]
                else if (accept && is_pair)
                    state_d = WID_HI_RD;
            end
            WID_PTR_RD: state_d = WID_HI_RD;
            WID_HI_RD:  state_d = WID_LO_RD;
            WID_LO_RD:  state_d = WID_LO_WR;
            WID_LO_WR:  state_d = WID_HI_WR;
            WID_HI_WR:  state_d = WID_FLAGS;
            WID_FLAGS:  state_d = WID_WAIT;
            WID_WAIT:
            begin
                if (cnt_q == `WID_INSTR_CYCLES)
                    state_d = WID_IDLE;                 // [RULE_08]
            end
            default:    state_d = WID_IDLE;
        endcase
    end

    // =========================================
    // registers
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            state_q <= WID_IDLE;
            cnt_q   <= 4'h0;
            addr_q  <= 8'h00;
            hi_q    <= 8'h00;
            lo_q    <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= accept ? 4'h1 : (cnt_q + 4'h1);
            if (accept)
                addr_q <= {i_dst[7:1], 1'b0};
            if (accept)
                lo_q <= 8'h00;
            if (state_q == WID_PTR_RD)
                addr_q <= even_ptr;                     // [RULE_05]
            if (state_q == WID_HI_RD)
                hi_q <= i_rf_rdata;                     // [RULE_06]
            if (state_q == WID_LO_RD)
                lo_q <= i_rf_rdata;                     // [RULE_06]
        end
    end

    // =========================================
    // outputs, registered
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            o_rf_addr  <= 8'h00;
            o_rf_wdata <= 8'h00;
            o_rf_we    <= 1'b0;
            o_flags    <= 8'h00;
            o_flags_we <= 1'b0;
            o_busy     <= 1'b0;
            o_done     <= 1'b0;
            o_illegal  <= 1'b0;
        end
        else
        begin
            o_rf_we    <= 1'b0;
            o_flags_we <= 1'b0;
            o_illegal  <= i_start && (state_q == WID_IDLE)
                          && !is_pair && !is_ind;
            o_busy     <= (state_d != WID_IDLE);
            o_done     <= (state_q == WID_WAIT) && (state_d == WID_IDLE);
            case (state_d)
                WID_PTR_RD: o_rf_addr <= i_dst;
                WID_HI_RD:  o_rf_addr <= (state_q == WID_PTR_RD)
                                         ? even_ptr
                                         : {i_dst[7:1], 1'b0};
                WID_LO_RD:  o_rf_addr <= addr_q | 8'h01;
                default:    o_rf_addr <= o_rf_addr;
            endcase
            if (state_q == WID_LO_WR)
            begin
                o_rf_addr  <= addr_q | 8'h01;
                o_rf_wdata <= sum[7:0];                 // [RULE_01]
                o_rf_we    <= 1'b1;
            end
            if (state_q == WID_HI_WR)
            begin
                o_rf_addr  <= addr_q;
                o_rf_wdata <= sum[15:8];                // [RULE_06]
                o_rf_we    <= 1'b1;
            end
            if (state_q == WID_FLAGS)
            begin
                o_flags             <= i_flags;         // [RULE_02]
                o_flags[`WID_FLAG_Z] <= zero;           // [RULE_02]
                o_flags[`WID_FLAG_S] <= sign;           // [RULE_03]
                o_flags[`WID_FLAG_V] <= ovf;            // [RULE_04]
                o_flags_we          <= 1'b1;
            end
        end
    end

    // =========================================
    // checks
    default clocking cb_chk
        @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);

    sequence s_go;
        accept && (is_pair || is_ind);
    endsequence
    sequence s_pair_go;
        accept && is_pair;
    endsequence
    sequence s_ind_go;
        accept && is_ind;
    endsequence
    sequence s_wr_lo;
        o_rf_we && o_rf_addr[0];
    endsequence
    sequence s_wr_hi;
        o_rf_we && !o_rf_addr[0];
    endsequence

    wr_order_a: assert property (s_wr_lo |=> s_wr_hi) // [RULE_06]
        else $error("high byte write did not follow low byte");
    flags_next_a: assert property (s_wr_hi |=> o_flags_we) // [RULE_02]
        else $error("flag update did not follow high byte write");
    pair_flow_a: assert property (s_pair_go |-> ##9 o_done) // [RULE_08]
        else $error("pair form did not finish in eight cycles");
    ind_done_a: assert property (s_ind_go |-> ##9 o_done) // [RULE_08]
        else $error("indirect form did not finish in eight cycles");
    busy_run_a: assert property (s_go |=> o_busy [*8]) // [RULE_08]
        else $error("busy dropped while an instruction ran");
    done_pulse_a: assert property (o_done |=> !o_done) // [RULE_08]
        else $error("done lasted more than one cycle");
    illegal_quiet_a: assert property ( // [RULE_08]
        o_illegal |-> !o_busy && !o_rf_we)
        else $error("unknown opcode started a transfer");
    ind_flow_a: assert property ( // [RULE_05]
        s_ind_go |=> o_rf_addr == $past(i_dst))
        else $error("indirect form did not read the pointer register");
    ptr_even_a: assert property ( // [RULE_01]
        (state_q == WID_HI_RD) |-> !o_rf_addr[0])
        else $error("high byte read from an odd address");
    pair_addr_a: assert property ( // [RULE_01]
        s_wr_lo |-> o_rf_addr == (addr_q | 8'h01))
        else $error("low byte written to wrong address");
    zero_flag_a: assert property ( // [RULE_02]
        o_flags_we |-> o_flags[`WID_FLAG_Z] == (sum == 16'h0000))
        else $error("zero flag wrong");
    keep_flags_a: assert property ( // [RULE_02]
        o_flags_we |-> o_flags[`WID_FLAG_C] == $past(i_flags[`WID_FLAG_C])
                    && o_flags[`WID_FLAG_D] == $past(i_flags[`WID_FLAG_D])
                    && o_flags[`WID_FLAG_H] == $past(i_flags[`WID_FLAG_H]))
        else $error("carry, decimal or half-carry disturbed");
    sign_flag_a: assert property ( // [RULE_03]
        o_flags_we |-> o_flags[`WID_FLAG_S] == o_rf_wdata[7])
        else $error("sign flag does not match the written high byte");
    ovf_flag_a: assert property ( // [RULE_04]
        o_flags_we |-> o_flags[`WID_FLAG_V] == (sum == 16'h8000))
        else $error("overflow flag wrong");
endmodule : wid_datapath

// >>> core/wid_pkg.sv
// types for the word increment datapath
package wid_pkg;
    typedef enum logic [3:0] {
        WID_IDLE    = 4'b0000,
        WID_PTR_RD  = 4'b0001,
        WID_HI_RD   = 4'b0010,
        WID_LO_RD   = 4'b0011,
        WID_LO_WR   = 4'b0100,
        WID_HI_WR   = 4'b0101,
        WID_FLAGS   = 4'b0110,
        WID_WAIT    = 4'b0111
    } wid_state_t;
endpackage : wid_pkg

// >>> core/wid_regs.svh
// constants for the word increment datapath
`ifndef WID_REGS_SVH
`define WID_REGS_SVH
`define WID_OPC_PAIR     8'hA0
`define WID_OPC_IND      8'hA1
`define WID_INSTR_CYCLES 4'h8
`define WID_WORD_ONE     16'h0001
`define WID_WORD_MAXPOS  16'h7FFF
`define WID_FLAG_C       0
`define WID_FLAG_Z       1
`define WID_FLAG_S       2
`define WID_FLAG_V       3
`define WID_FLAG_D       4
`define WID_FLAG_H       5
`endif

// >>> tb/wid_datapath_tb_top.sv
// self-checking bench for the word increment datapath
`timescale 1ns/1ps
module wid_datapath_tb_top;
    // ========================================
    // signals and register file stand-in
    typedef struct {
        logic [7:0]  opc, dst, ptr, fin, ef;
        logic [15:0] word, ew;
    } wid_row_t;
    logic        i_mclk = 1'b0;
    logic        i_rst = 1'b1;
    logic        i_start = 1'b0;
    logic [7:0]  i_opcode = 8'h00;
    logic [7:0]  i_dst = 8'h00;
    logic [7:0]  i_flags = 8'h00;
    wire  [7:0]  i_rf_rdata;
    logic [7:0]  o_rf_addr, o_rf_wdata, o_flags;
    logic        o_rf_we, o_flags_we, o_busy, o_done, o_illegal;
    logic [7:0]  rf [256];
    logic [7:0]  fl_seen, a;
    int          fails = 0, checks = 0, wcnt = 0, n;
    wid_row_t    rows [6] = '{
        '{8'hA0, 8'h10, 8'h00, 8'h31, 8'h3D, 16'h7FFF, 16'h8000},
        '{8'hA0, 8'h21, 8'h00, 8'h0E, 8'h02, 16'hFFFF, 16'h0000},
        '{8'hA0, 8'h30, 8'h00, 8'h00, 8'h00, 16'h0FFF, 16'h1000},
        '{8'hA1, 8'h40, 8'h53, 8'h02, 8'h04, 16'h8000, 16'h8001},
        '{8'hA1, 8'h41, 8'h02, 8'h3F, 8'h31, 16'h00FF, 16'h0100},
        '{8'hA1, 8'h45, 8'h61, 8'h08, 8'h02, 16'hFFFF, 16'h0000}};
    always #10 i_mclk = ~i_mclk;
    assign i_rf_rdata = rf[o_rf_addr];
    always @(posedge i_mclk)
    begin
        if (o_rf_we) begin rf[o_rf_addr] <= o_rf_wdata; wcnt++; end
        if (o_flags_we) fl_seen <= o_flags;
    end
    wid_datapath dut (.i_mclk(i_mclk), .i_rst(i_rst), .i_start(i_start),
        .i_opcode(i_opcode), .i_dst(i_dst), .i_flags(i_flags),
        .i_rf_rdata(i_rf_rdata), .o_rf_addr(o_rf_addr),
        .o_rf_wdata(o_rf_wdata), .o_rf_we(o_rf_we), .o_flags(o_flags),
        .o_flags_we(o_flags_we), .o_busy(o_busy), .o_done(o_done),
        .o_illegal(o_illegal));
    // ========================================
    // shared tasks
    task check(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task summarize;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : summarize
    // start one instruction, optionally re-pulse start while busy
    task issue(input logic [7:0] opc, dst, fin, input bit dup);
        @(posedge i_mclk);
        i_start <= 1'b1; i_opcode <= opc; i_dst <= dst; i_flags <= fin;
        n = 0;
        do
        begin
            @(posedge i_mclk);
            n++;
            i_start <= dup && (n == 2);
            #1;
            if (n == 1) check(o_busy, 1'b1);
            if (n > 20) begin fails++; summarize(); end
        end
        while (o_done !== 1'b1);
    endtask : issue
    // ========================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        check({o_busy, o_done, o_rf_we, o_flags_we, o_illegal}, 0);
        check(o_flags, 0);
        foreach (rows[i])
        begin
            a = (rows[i].opc == 8'hA1) ? {rows[i].ptr[7:1], 1'b0}
                                       : {rows[i].dst[7:1], 1'b0};
            rf[rows[i].dst] = rows[i].ptr;
            {rf[a], rf[a + 8'h01]} = rows[i].word;
            issue(rows[i].opc, rows[i].dst, rows[i].fin, 1'b0);
            check(n - 1, 8);
            check(o_busy, 1'b0);
            check((rf[a] | rf[a + 8'h01]) == 8'h00, rows[i].ew == 16'h0000);
            check({rf[a], rf[a + 8'h01]}, rows[i].ew);
            check(fl_seen, rows[i].ef);
            if (rows[i].opc == 8'hA1)
                check(rf[rows[i].dst], rows[i].ptr);
        end
        // start while busy must not run a second increment
        {rf[8'h70], rf[8'h71]} = 16'h00FF;
        issue(8'hA0, 8'h70, 8'h00, 1'b1);
        repeat (10) @(posedge i_mclk);
        #1;
        check({rf[8'h70], rf[8'h71]}, 16'h0100);
        // reset in mid-run drops the instruction with no write
        n = wcnt;
        {rf[8'h80], rf[8'h81]} = 16'h1234;
        @(posedge i_mclk);
        i_start <= 1'b1; i_opcode <= 8'hA0; i_dst <= 8'h80;
        @(posedge i_mclk);
        i_start <= 1'b0;
        @(posedge i_mclk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_rst <= 1'b0;
        #1;
        check({o_busy, o_rf_we, o_flags_we, o_done}, 0);
        check(wcnt, n);
        issue(8'hA0, 8'h80, 8'h00, 1'b0);
        check({rf[8'h80], rf[8'h81]}, 16'h1235);
        // unknown opcode gives a single illegal pulse, no writes
        n = wcnt;
        @(posedge i_mclk);
        i_start <= 1'b1; i_opcode <= 8'h20; i_dst <= 8'h70;
        @(posedge i_mclk);
        i_start <= 1'b0;
        #1;
        check(o_illegal, 1'b1);
        repeat (10) @(posedge i_mclk);
        #1;
        check(wcnt, n);
        check(o_busy, 1'b0);
        check(o_illegal, 1'b0);
        summarize();
    end
endmodule : wid_datapath_tb_top
